// ==== hdl/bem_matcher.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bem_matcher
   import bem_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_cycle_end,
   input wire logic bus_rw,
   input wire logic bus_di,
   input wire logic [bem_pkg::PROBE_W-1:0] bus_probe,
   input wire logic [bem_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [bem_pkg::DATA_W-1:0] bus_data,
   output logic [bem_pkg::NUM_TERMS-1:0] term_hit,
   output logic break_req,
   output logic irq,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [bem_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [bem_pkg::AXI_DW-1:0] s_axi_wdata,
   input wire logic [bem_pkg::AXI_SW-1:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [bem_pkg::AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [bem_pkg::AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   import bem_pkg::*;

   // Register access strobes from the bus slave
   bem_reg_if rif ();

   // Term index of an address inside the term block
   function automatic logic [1:0] term_idx(input logic [AXI_AW-1:0] a);
      logic [AXI_AW-1:0] q;
      q = a / REG_TERM_STRIDE;
      return q[1:0];
   endfunction

   // Offset of an address within its term block
   function automatic logic [AXI_AW-1:0] term_off(input logic [AXI_AW-1:0] a);
      return a % REG_TERM_STRIDE;
   endfunction

   // True for every address that holds a register
   function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
      logic ok;
      ok = 1'b0;
      if (a < REG_TERM_END) begin
         ok = (term_off(a) == REG_TERM_CTRL) || (term_off(a) == REG_TERM_VALUE) ||
            (term_off(a) == REG_TERM_DCARE);
      end else if (a == REG_STATUS || a == REG_IRQ_MASK || a == REG_SNAPSHOT) begin
         ok = 1'b1;
      end else if (a == REG_PROBE_REC || a == REG_HITS) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   // Merge write data into a word under the byte strobes
   function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
      input logic [AXI_DW-1:0] wd, input logic [AXI_SW-1:0] st);
      logic [AXI_DW-1:0] r;
      r = old;
      for (int b = 0; b < AXI_SW; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Pin synchronisers, two stages each
   logic cyc_m_q, cyc_s_q, cyc_p_q; // Cycle strobe stages plus edge history
   logic [WORD_W-1:0] smp_m_q, smp_s_q; // Assembled bus word stages
   logic [PROBE_W-1:0] prb_m_q, prb_s_q; // Raw probe stages, all clips
   logic [WORD_W-1:0] pin_word; // Bus pins in compare word order
   logic cyc_edge; // End of one target cycle

   // Compare word layout: read/write on top, data bit zero at bottom
   always_comb begin
      pin_word = WORD_ZERO;
      pin_word[POS_RW] = bus_rw;
      pin_word[POS_DI] = bus_di;
      pin_word[POS_PROBE_LO +: PROBE_CMP_W] = bus_probe[PROBE_CMP_W-1:0];
      pin_word[POS_ADDR_LO +: ADDR_W] = bus_addr;
      pin_word[POS_DATA_LO +: DATA_W] = bus_data;
   end

   // Synchroniser flops, no logic between the stages
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cyc_m_q <= 1'b0;
         cyc_s_q <= 1'b0;
         cyc_p_q <= 1'b0;
         smp_m_q <= WORD_ZERO;
         smp_s_q <= WORD_ZERO;
         prb_m_q <= '0;
         prb_s_q <= '0;
      end else begin
         cyc_m_q <= bus_cycle_end;
         cyc_s_q <= cyc_m_q;
         cyc_p_q <= cyc_s_q;
         smp_m_q <= pin_word;
         smp_s_q <= smp_m_q;
         prb_m_q <= bus_probe;
         prb_s_q <= prb_m_q;
      end
   end

   // Rising edge of the synchronised cycle strobe
   assign cyc_edge = cyc_s_q && !cyc_p_q;

   // Snapshot and evaluation state
   logic [WORD_W-1:0] snap_q, snap_d; // Word of the last target cycle
   logic [PROBE_W-1:0] prec_q, prec_d; // Every probe, kept for readout only
   logic eval_q, eval_d; // Snapshot fresh this cycle
   logic [NUM_TERMS-1:0] hit_q, hit_d; // Registered term hits, one pulse
   logic brk_q, brk_d; // Breakpoint request pulse
   logic [NUM_TERMS-1:0] hit_now; // Comparator results on the snapshot

   // Term configuration
   logic [NUM_TERMS-1:0][CTRL_W-1:0] ctrl_q, ctrl_d; // Enable, break, span, negate
   bem_words_t val_q, val_d; // Compare values
   bem_words_t dc_q, dc_d; // Don't-care masks, one means ignore

   // Interrupt state
   logic [STAT_W-1:0] stat_q, stat_d; // Sticky events
   logic [STAT_W-1:0] imask_q, imask_d; // One enables the event onto irq
   logic irq_q, irq_d; // Registered interrupt level
   logic [STAT_W-1:0] ev_set; // Events of this cycle
   logic [STAT_W-1:0] ev_clr; // Write-one-to-clear bits
   logic [AXI_DW-1:0] wword; // Strobed write image for the status clear
   logic [AXI_DW-1:0] mword; // Mask merged with the strobed write

   // Read data path
   logic [AXI_DW-1:0] rdata;

   // Four comparators on one snapshot
   bem_term_eval u_eval (
      .word(snap_q),
      .value(val_q),
      .dcare(dc_q),
      .ctrl(ctrl_q),
      .hit(hit_now)
   );

   // Register bus slave
   bem_axil_slave u_axil (
      .sys_clk(sys_clk),
      .rst(rst),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .rif(rif.bus)
   );

   // Snapshot capture and hit registration
   always_comb begin
      snap_d = snap_q;
      prec_d = prec_q;
      eval_d = cyc_edge;
      hit_d = '0;
      brk_d = 1'b0;
      // New target cycle: take the whole word at once
      if (cyc_edge) begin
         snap_d = smp_s_q;
         prec_d = prb_s_q;
      end
      // One cycle later the comparators have settled on it
      if (eval_q) begin
         hit_d = hit_now;
         brk_d = |(hit_now & breaks(ctrl_q));
      end
   end

   // Break flags of the enabled terms in the control table
   function automatic logic [NUM_TERMS-1:0] breaks(
      input logic [NUM_TERMS-1:0][CTRL_W-1:0] c);
      logic [NUM_TERMS-1:0] r;
      for (int k = 0; k < NUM_TERMS; k++) begin
         r[k] = c[k][CTRL_BREAK] && c[k][CTRL_ENABLE];
      end
      return r;
   endfunction

   // Snapshot registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         snap_q <= WORD_ZERO;
         prec_q <= '0;
         eval_q <= 1'b0;
         hit_q <= '0;
         brk_q <= 1'b0;
      end else begin
         snap_q <= snap_d;
         prec_q <= prec_d;
         eval_q <= eval_d;
         hit_q <= hit_d;
         brk_q <= brk_d;
      end
   end

   // Term configuration writes
   always_comb begin
      ctrl_d = ctrl_q;
      val_d = val_q;
      dc_d = dc_q;
      if (rif.wr_en && rif.wr_addr < REG_TERM_END) begin
         // Control word: only the low flag bits exist
         if (term_off(rif.wr_addr) == REG_TERM_CTRL) begin
            ctrl_d[term_idx(rif.wr_addr)] = rif.wr_data[CTRL_W-1:0];
            // Term A keeps no span flag
            if (term_idx(rif.wr_addr) == 2'h0) begin
               ctrl_d[0][CTRL_SPAN] = 1'b0;
            end
         end else if (term_off(rif.wr_addr) == REG_TERM_VALUE) begin
            // Full 32-bit pattern per term
            val_d[term_idx(rif.wr_addr)] = merge(val_q[term_idx(rif.wr_addr)],
               rif.wr_data, rif.wr_strb);
         end else if (term_off(rif.wr_addr) == REG_TERM_DCARE) begin
            // Per-bit don't-care for every field
            dc_d[term_idx(rif.wr_addr)] = merge(dc_q[term_idx(rif.wr_addr)],
               rif.wr_data, rif.wr_strb);
         end
      end
   end

   // Configuration registers, all terms disabled at reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= '0;
         val_q <= '0;
         dc_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         val_q <= val_d;
         dc_q <= dc_d;
      end
   end

   // Status events and interrupt level
   always_comb begin
      ev_set = {brk_d, hit_d};
      wword = merge(WORD_ZERO, rif.wr_data, rif.wr_strb);
      mword = merge(AXI_DW'(imask_q), rif.wr_data, rif.wr_strb);
      ev_clr = '0;
      imask_d = imask_q;
      if (rif.wr_en && rif.wr_addr == REG_STATUS) begin
         ev_clr = wword[STAT_W-1:0];
      end else if (rif.wr_en && rif.wr_addr == REG_IRQ_MASK) begin
         imask_d = mword[STAT_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      stat_d = ev_set | (stat_q & ~ev_clr);
      irq_d = |(stat_d & imask_d);
   end

   // Interrupt registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_q <= '0;
         imask_q <= '0;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         imask_q <= imask_d;
         irq_q <= irq_d;
      end
   end

   // Read decode, answered in the cycle after the address is taken
   always_comb begin
      rdata = '0;
      if (rif.rd_addr < REG_TERM_END) begin
         if (term_off(rif.rd_addr) == REG_TERM_CTRL) begin
            rdata[CTRL_W-1:0] = ctrl_q[term_idx(rif.rd_addr)];
         end else if (term_off(rif.rd_addr) == REG_TERM_VALUE) begin
            rdata = val_q[term_idx(rif.rd_addr)];
         end else if (term_off(rif.rd_addr) == REG_TERM_DCARE) begin
            rdata = dc_q[term_idx(rif.rd_addr)];
         end
      end else if (rif.rd_addr == REG_STATUS) begin
         rdata[STAT_W-1:0] = stat_q;
      end else if (rif.rd_addr == REG_IRQ_MASK) begin
         rdata[STAT_W-1:0] = imask_q;
      end else if (rif.rd_addr == REG_SNAPSHOT) begin
         rdata = snap_q;
      end else if (rif.rd_addr == REG_PROBE_REC) begin
         rdata[PROBE_W-1:0] = prec_q;
      end else if (rif.rd_addr == REG_HITS) begin
         rdata[NUM_TERMS-1:0] = hit_q;
      end
   end

   // Answers to the bus slave
   assign rif.rd_data = rdata;
   assign rif.rd_err = !is_mapped(rif.rd_addr);
   assign rif.wr_err = !is_mapped(rif.wr_addr);

   // Outputs straight from flops
   assign term_hit = hit_q;
   assign break_req = brk_q;
   assign irq = irq_q;
endmodule

// ==== hdl/bem_pkg.sv ====
package bem_pkg;
   // Term count and compare word geometry
   localparam int NUM_TERMS = 4;
   localparam int WORD_W = 32;
   localparam int PROBE_W = 8;
   localparam int PROBE_CMP_W = 5;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   // Field positions inside the compare word, read/write on top
   localparam int POS_RW = 31;
   localparam int POS_DI = 30;
   localparam int POS_PROBE_LO = 25;
   localparam int POS_ADDR_LO = 8;
   localparam int POS_DATA_LO = 0;
   // Register bus geometry
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam int AXI_SW = 4;
   // Register offsets: one 16-byte block per term
   localparam logic [AXI_AW-1:0] REG_TERM_STRIDE = 8'h10;
   localparam logic [AXI_AW-1:0] REG_TERM_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_TERM_VALUE = 8'h04;
   localparam logic [AXI_AW-1:0] REG_TERM_DCARE = 8'h08;
   localparam logic [AXI_AW-1:0] REG_TERM_END = 8'h40;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h40;
   localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h44;
   localparam logic [AXI_AW-1:0] REG_SNAPSHOT = 8'h48;
   localparam logic [AXI_AW-1:0] REG_PROBE_REC = 8'h4C;
   localparam logic [AXI_AW-1:0] REG_HITS = 8'h50;
   // Control bits of a term
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_BREAK = 1;
   localparam int CTRL_SPAN = 2;
   localparam int CTRL_NEGATE = 3;
   localparam int CTRL_W = 4;
   // Status layout: one bit per term, then breakpoint
   localparam int STAT_BRK = 4;
   localparam int STAT_W = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;
   typedef logic [NUM_TERMS-1:0][WORD_W-1:0] bem_words_t;
endpackage

// ==== hdl/bem_reg_if.sv ====
`timescale 1ns/1ps
interface bem_reg_if;
   import bem_pkg::*;
   logic wr_en; // One-cycle write pulse
   logic [AXI_AW-1:0] wr_addr;
   logic [AXI_DW-1:0] wr_data;
   logic [AXI_SW-1:0] wr_strb;
   logic wr_err; // Address not mapped
   logic rd_en; // One-cycle read pulse
   logic [AXI_AW-1:0] rd_addr;
   logic [AXI_DW-1:0] rd_data;
   logic rd_err;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_err, rd_data, rd_err);
endinterface

// ==== hdl/bem_axil_slave.sv ====
`timescale 1ns/1ps
module bem_axil_slave
   import bem_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [AXI_SW-1:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   bem_reg_if.bus rif
);
   logic aw_q, aw_d, w_q, w_d, b_q, b_d, ar_q, ar_d, rp_q, rp_d, r_q, r_d;
   logic [AXI_AW-1:0] awa_q, awa_d, ara_q, ara_d;
   logic [AXI_DW-1:0] wd_q, wd_d, rd_q, rd_d;
   logic [AXI_SW-1:0] ws_q, ws_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   // Ready flags drop on capture and return once the answer is taken
   always_comb begin
      aw_d = aw_q; w_d = w_q; b_d = b_q; ar_d = ar_q; rp_d = 1'b0; r_d = r_q;
      awa_d = awa_q; ara_d = ara_q; wd_d = wd_q; ws_d = ws_q;
      rd_d = rd_q; br_d = br_q; rr_d = rr_q;
      if (s_axi_awvalid && aw_q) begin
         aw_d = 1'b0; awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && w_q) begin
         w_d = 1'b0; wd_d = s_axi_wdata; ws_d = s_axi_wstrb;
      end
      // Both halves held: write goes to the register file
      if (!aw_q && !w_q && !b_q) begin
         b_d = 1'b1; br_d = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (b_q && s_axi_bready) begin
         b_d = 1'b0; aw_d = 1'b1; w_d = 1'b1;
      end
      if (s_axi_arvalid && ar_q) begin
         ar_d = 1'b0; ara_d = s_axi_araddr; rp_d = 1'b1;
      end
      // Read data is captured one cycle after the address
      if (rp_q) begin
         r_d = 1'b1; rd_d = rif.rd_data; rr_d = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (r_q && s_axi_rready) begin
         r_d = 1'b0; ar_d = 1'b1;
      end
   end
   // Handshake state registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_q <= 1'b1; w_q <= 1'b1; b_q <= 1'b0; ar_q <= 1'b1; rp_q <= 1'b0;
         r_q <= 1'b0; awa_q <= '0; ara_q <= '0; wd_q <= '0; ws_q <= '0;
         rd_q <= '0; br_q <= RESP_OKAY; rr_q <= RESP_OKAY;
      end else begin
         aw_q <= aw_d; w_q <= w_d; b_q <= b_d; ar_q <= ar_d; rp_q <= rp_d;
         r_q <= r_d; awa_q <= awa_d; ara_q <= ara_d; wd_q <= wd_d; ws_q <= ws_d;
         rd_q <= rd_d; br_q <= br_d; rr_q <= rr_d;
      end
   end
   assign rif.wr_en = !aw_q && !w_q && !b_q;
   assign rif.wr_addr = awa_q;
   assign rif.wr_data = wd_q;
   assign rif.wr_strb = ws_q;
   assign rif.rd_en = rp_q;
   assign rif.rd_addr = ara_q;
   assign s_axi_awready = aw_q;
   assign s_axi_wready = w_q;
   assign s_axi_bvalid = b_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ar_q;
   assign s_axi_rvalid = r_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
endmodule

// ==== hdl/bem_term_eval.sv ====
`timescale 1ns/1ps
module bem_term_eval
   import bem_pkg::*;
(
   input wire logic [WORD_W-1:0] word,
   input wire bem_words_t value,
   input wire bem_words_t dcare,
   input wire logic [NUM_TERMS-1:0][CTRL_W-1:0] ctrl,
   output logic [NUM_TERMS-1:0] hit
);
   // One comparator slice per term, span taken from the term below
   for (genvar k = 0; k < NUM_TERMS; k++) begin : g_term
      logic raw, span, lower, base;
      // Ternary compare: don't-care bits never mismatch
      assign raw = ~|((word ^ value[k]) & ~dcare[k]);
      if (k == 0) begin : g_first
         assign span = 1'b0;
      end else begin : g_span
         // Whole word between lower and upper pattern, both enabled
         assign span = ctrl[k][CTRL_ENABLE] && ctrl[k-1][CTRL_ENABLE] &&
            (word >= value[k-1]) && (word <= value[k]);
      end
      if (k == NUM_TERMS - 1) begin : g_last
         assign lower = 1'b0;
      end else begin : g_low
         // A term that opens a span stops matching alone
         assign lower = ctrl[k+1][CTRL_SPAN];
      end
      assign base = (k > 0 && ctrl[k][CTRL_SPAN]) ? span : (raw && !lower);
      // Negation after the compare, enable gates everything
      assign hit[k] = ctrl[k][CTRL_ENABLE] && (base ^ ctrl[k][CTRL_NEGATE]);
   end
endmodule

// ==== dv/bem_matcher_properties.sv ====
`timescale 1ns/1ps
module bem_matcher_properties
   import bem_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_cycle_end,
   input wire logic [NUM_TERMS-1:0] term_hit,
   input wire logic break_req,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [AXI_DW-1:0] s_axi_rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Both write channels taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read address taken
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   brk_has_hit_a: assert property (break_req |-> term_hit != '0)
      else $error("break without hit");
   hit_pulse_a: assert property (term_hit != '0 |=> term_hit == '0)
      else $error("hit too long");
   brk_pulse_a: assert property (break_req |=> !break_req)
      else $error("break too long");
   hit_after_strobe_a: assert property (term_hit != '0 |-> $past(bus_cycle_end, 4)
      && !$past(bus_cycle_end, 5)) else $error("hit without strobe");
   wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (rd_taken |-> ##2 s_axi_rvalid)
      else $error("read response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   aw_busy_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready while busy");
endmodule
bind bem_matcher bem_matcher_properties chk_u (.sys_clk(sys_clk), .rst(rst),
   .bus_cycle_end(bus_cycle_end), .term_hit(term_hit), .break_req(break_req),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ==== dv/bem_target_model.sv ====
`timescale 1ns/1ps
module bem_target_model
   import bem_pkg::*;
(
   input wire logic sys_clk,
   output logic bus_cycle_end,
   output logic bus_rw,
   output logic bus_di,
   output logic [PROBE_W-1:0] bus_probe,
   output logic [ADDR_W-1:0] bus_addr,
   output logic [DATA_W-1:0] bus_data
);
   // Idle bus at time zero
   initial begin
      {bus_cycle_end, bus_rw, bus_di, bus_probe, bus_addr, bus_data} = '0;
   end
   // One target cycle; pins steady three clocks each side of the strobe rise
   task automatic drive_cycle(input logic [WORD_W-1:0] w, input logic [2:0] rec);
      @(posedge sys_clk);
      {bus_rw, bus_di, bus_probe, bus_addr, bus_data} <= {w[31:30], rec, w[29:0]};
      repeat (3) @(posedge sys_clk);
      bus_cycle_end <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus_cycle_end <= 1'b0;
      // Released pins no longer show the old word
      {bus_rw, bus_di, bus_probe, bus_addr, bus_data} <= ~{w[31:30], rec, w[29:0]};
   endtask
endmodule

// ==== dv/bem_matcher_test.sv ====
`timescale 1ns/1ps
module bem_matcher_test;
   import bem_pkg::*;
   logic sys_clk, rst, bus_cycle_end, bus_rw, bus_di, break_req, irq;
   logic [PROBE_W-1:0] bus_probe;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_data;
   logic [NUM_TERMS-1:0] term_hit;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
   logic [AXI_SW-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares = 0;
   int check_count = 0;
   localparam logic [31:0] W0 = 32'h9412345A; // Read, fetch, probes 0A, addr 01234, data 5A
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   bem_matcher dut_u (.sys_clk(sys_clk), .rst(rst), .bus_cycle_end(bus_cycle_end),
      .bus_rw(bus_rw), .bus_di(bus_di), .bus_probe(bus_probe), .bus_addr(bus_addr),
      .bus_data(bus_data), .term_hit(term_hit), .break_req(break_req), .irq(irq),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp));
   bem_target_model tgt_u (.sys_clk(sys_clk), .bus_cycle_end(bus_cycle_end),
      .bus_rw(bus_rw), .bus_di(bus_di), .bus_probe(bus_probe), .bus_addr(bus_addr),
      .bus_data(bus_data));
   // Verdict and end of run
   task automatic report_and_stop();
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Register write; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Register read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Program one term: value, don't-care mask, control
   task automatic set_term(input int k, input logic [3:0] c, input logic [31:0] v,
      input logic [31:0] m);
      logic [1:0] r;
      logic [7:0] b;
      b = 8'(k) * REG_TERM_STRIDE;
      wr(b + REG_TERM_VALUE, v, r);
      wr(b + REG_TERM_DCARE, m, r);
      wr(b + REG_TERM_CTRL, 32'(c), r);
   endtask
   // One target cycle; collect hit and break pulses
   task automatic run_cycle(input logic [31:0] w, input logic [3:0] eh, input logic eb);
      logic [3:0] h = '0;
      logic b = 1'b0;
      fork
         tgt_u.drive_cycle(w, 3'h5);
         repeat (16) begin
            @(posedge sys_clk);
            h |= term_hit;
            b |= break_req;
         end
      join
      chk("term_hit", 32'(eh), 32'(h));
      chk("break_req", 32'(eb), 32'(b));
   endtask
   // Reset values and unmapped access
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      chk("irq", 32'h0, 32'(irq));
      rd(REG_TERM_CTRL, d, r);
      chk("ctrl_a", 32'h0, d);
      rd(8'h60, d, r);
      chk("rd_resp", 32'(RESP_SLVERR), 32'(r));
      chk("rd_data", 32'h0, d);
      wr(8'h60, 32'hFFFFFFFF, r);
      chk("wr_resp", 32'(RESP_SLVERR), 32'(r));
   endtask
   // Exact match per field but the low data nibble, whose flips are don't-care; term B negated copy with breakpoint
   task automatic t_match();
      logic [31:0] fl [6];
      logic a;
      fl = '{32'h0, 32'h5, 32'h80000000, 32'h40000000, 32'h02000000, 32'h100};
      set_term(0, 4'h1, W0, 32'h0000000F);
      set_term(1, 4'hB, W0, 32'h0000000F);
      for (int i = 0; i < 6; i++) begin
         a = (i < 2);
         run_cycle(W0 ^ fl[i], {2'b00, ~a, a}, ~a);
      end
   endtask
   // Sticky status, mask and clear
   task automatic t_irq();
      logic [31:0] d;
      logic [1:0] r;
      wr(REG_STATUS, 32'h1F, r);
      wr(REG_IRQ_MASK, 32'h01, r);
      run_cycle(W0 ^ 32'h10, 4'h2, 1'b1);
      chk("irq", 32'h0, 32'(irq));
      rd(REG_STATUS, d, r);
      chk("status", 32'h12, d);
      run_cycle(W0, 4'h1, 1'b0);
      chk("irq", 32'h1, 32'(irq));
      wr(REG_STATUS, 32'h01, r);
      chk("irq", 32'h0, 32'(irq));
      rd(REG_STATUS, d, r);
      chk("status", 32'h12, d);
   endtask
   // Don't-care on control, probe and address bits
   task automatic t_dcare();
      set_term(0, 4'h1, W0, 32'hC2000100);
      run_cycle(W0 ^ 32'hC2000100, 4'h3, 1'b1);
   endtask
   // Ranges over the whole word, disabled term, no span on A
   task automatic t_span();
      logic [31:0] d;
      logic [1:0] r;
      set_term(0, 4'h1, 32'h00010000, 32'h0);
      set_term(1, 4'h5, 32'h80001000, 32'h0);
      set_term(2, 4'h1, 32'hA0000000, 32'h0);
      set_term(3, 4'h5, 32'hB0000000, 32'h0);
      run_cycle(32'h00010000, 4'h2, 1'b0);
      run_cycle(32'h80000500, 4'h2, 1'b0);
      run_cycle(32'h80001000, 4'h2, 1'b0);
      run_cycle(32'h80001001, 4'h0, 1'b0);
      run_cycle(32'hA8000000, 4'h8, 1'b0);
      set_term(1, 4'h1, 32'h80001000, 32'h0);
      set_term(2, 4'h5, 32'hA0000000, 32'h0);
      run_cycle(32'h90000000, 4'h4, 1'b0);
      set_term(3, 4'h4, 32'hB0000000, 32'h0);
      run_cycle(32'hA8000000, 4'h0, 1'b0);
      wr(REG_TERM_CTRL, 32'hF, r);
      rd(REG_TERM_CTRL, d, r);
      chk("ctrl_a", 32'hB, d & 32'hF);
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
         s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_match();
      t_irq();
      t_dcare();
      t_span();
      report_and_stop();
   end
endmodule
